// >>> rtl/owc_dev.sv
// Purpose: Device end of the single-wire, UART-style configuration port.
// Assumes: One 50 MHz clock; user logic answers reads on the same clock.
// Notes:   Write words queue in a FIFO; a full FIFO drops the word.
`include "owc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module owc_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign o_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_valid = (count_reg != '0);
  assign o_data  = mem[rd_ptr_reg];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : owc_fifo

module owc_dev #(
  parameter int unsigned TIMEOUT_CYCLES = `OWC_TO_CYCLES,
  parameter int unsigned FIFO_DEPTH     = 16
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  owc_if.dev                 link,
  input  wire logic [3:0]    i_turn_bits,
  output logic               o_wr_valid,
  input  wire logic          i_wr_ready,
  output owc_pkg::owc_addr_type o_wr_addr,
  output owc_pkg::owc_word_type o_wr_data,
  output logic               o_rd_req,
  output owc_pkg::owc_addr_type o_rd_addr,
  input  wire owc_pkg::owc_word_type i_rd_data,
  output logic               o_overflow,
  output logic               o_frame_err
);
  import owc_pkg::*;

  localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);

  owc_dev_state_type state_reg;
  logic [2:0]   sync_reg;
  logic         line_reg;
  logic         line_next;
  logic         rise;
  logic         fall;
  logic [16:0]  meas_reg;
  logic [2:0]   rises_reg;
  owc_per_type  per_reg;
  logic [17:0]  timer_reg;
  logic [3:0]   bit_reg;
  logic [7:0]   rx_reg;
  logic [9:0]   tx_reg;
  logic [7:0]   hi_reg;
  logic         tx_hi_reg;
  logic [1:0]   phase_reg;
  logic [7:0]   lo_reg;
  owc_addr_type addr_reg;
  logic         oe_reg;
  logic         byte_done_reg;
  logic         push_reg;
  logic [TW-1:0] to_reg;
  logic         fifo_ready;
  logic [3:0]   turn_bits;

  assign link.dev_out = 1'b0;
  assign link.dev_oe  = oe_reg;
  assign turn_bits    = (i_turn_bits == 4'd0) ? `OWC_TURN_DEF : i_turn_bits;

  // ===========================================================================
  // Line synchroniser and glitch filter
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_reg <= 3'b111;
      line_reg <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], link.line};
      line_reg <= line_next;
    end
  end

  always_comb begin
    line_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : line_reg;
    rise      = ~line_reg & line_next;
    fall      = line_reg & ~line_next;
  end

  // ===========================================================================
  // Inactivity timeout
  always_ff @(posedge i_clock) begin
    if (i_rst || state_reg == DEV_HUNT || byte_done_reg) begin
      to_reg <= '0;
    end else if (to_reg != TW'(TIMEOUT_CYCLES)) begin
      to_reg <= to_reg + 1'b1;
    end
  end

  // ===========================================================================
  // Transaction sequencer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg     <= DEV_HUNT;
      meas_reg      <= '0;
      rises_reg     <= '0;
      per_reg       <= '0;
      timer_reg     <= '0;
      bit_reg       <= '0;
      rx_reg        <= '0;
      tx_reg        <= '1;
      hi_reg        <= '0;
      tx_hi_reg     <= 1'b0;
      phase_reg     <= '0;
      lo_reg        <= '0;
      addr_reg      <= '0;
      oe_reg        <= 1'b0;
      byte_done_reg <= 1'b0;
      push_reg      <= 1'b0;
      o_rd_req      <= 1'b0;
      o_rd_addr     <= '0;
      o_overflow    <= 1'b0;
      o_frame_err   <= 1'b0;
    end else begin
      byte_done_reg <= 1'b0;
      push_reg      <= 1'b0;
      o_rd_req      <= 1'b0;
      o_overflow    <= 1'b0;
      o_frame_err   <= 1'b0;
      if (state_reg != DEV_HUNT && to_reg == TW'(TIMEOUT_CYCLES)) begin
        state_reg <= DEV_HUNT;
        oe_reg    <= 1'b0;
      end else begin
        unique case (state_reg)
          DEV_HUNT: begin
            phase_reg <= '0;
            if (fall) begin
              state_reg <= DEV_SYNC;
              rises_reg <= '0;
              meas_reg  <= '0;
            end
          end
          DEV_SYNC: begin
            meas_reg <= meas_reg + 1'b1;
            if (rise) begin
              rises_reg <= rises_reg + 1'b1;
              if (rises_reg == 3'd0) begin
                // Counting from one makes the total equal the cycles between the edges.
                meas_reg <= 17'd1;
              end else if (rises_reg == `OWC_SYNC_RISES) begin
                // Five rising edges span eight bit periods of the pattern.
                if (meas_reg >= 17'(8 * `OWC_PER_MIN)) begin
                  per_reg   <= owc_per_type'(meas_reg >> `OWC_SYNC_SHIFT);
                  state_reg <= DEV_IDLE;
                  byte_done_reg <= 1'b1;
                end else begin
                  state_reg <= DEV_HUNT;
                end
              end
            end else if (meas_reg > 17'(`OWC_MEAS_MAX)) begin
              state_reg <= DEV_HUNT;
            end
          end
          DEV_IDLE: begin
            if (fall) begin
              state_reg <= DEV_RX;
              timer_reg <= 18'(per_reg >> 1);
              bit_reg   <= '0;
            end
          end
          DEV_RX: begin
            if (timer_reg != '0) begin
              timer_reg <= timer_reg - 1'b1;
            end else begin
              timer_reg <= 18'(per_reg) - 18'd1;
              bit_reg   <= bit_reg + 1'b1;
              if (bit_reg == 4'd0 && line_reg) begin
                state_reg <= DEV_IDLE;
              end else if (bit_reg != `OWC_LAST_BIT) begin
                if (bit_reg != 4'd0) begin
                  rx_reg <= {line_reg, rx_reg[7:1]};
                end
              end else if (!line_reg) begin
                o_frame_err <= 1'b1;
                state_reg   <= DEV_HUNT;
              end else begin
                byte_done_reg <= 1'b1;
                state_reg     <= DEV_IDLE;
                unique case (phase_reg)
                  2'd0: begin
                    if (rx_reg[`OWC_RD_BIT]) begin
                      o_rd_addr <= rx_reg[3:0];
                      o_rd_req  <= 1'b1;
                      // The second half of the stop bit is waited out as well, so the
                      // turnaround counts from the end of the byte, not its mid-sample.
                      timer_reg <= 18'(per_reg) * 18'(turn_bits)
                                   + 18'(per_reg >> 1) - 18'd1;
                      state_reg <= DEV_TURN;
                    end else begin
                      addr_reg  <= rx_reg[3:0];
                      phase_reg <= 2'd1;
                    end
                  end
                  2'd1: begin
                    lo_reg    <= rx_reg;
                    phase_reg <= 2'd2;
                  end
                  default: begin
                    // A full queue cannot stall the wire, so the word is lost.
                    push_reg   <= fifo_ready;
                    o_overflow <= ~fifo_ready;
                    state_reg  <= DEV_HUNT;
                  end
                endcase
              end
            end
          end
          DEV_TURN: begin
            if (timer_reg != '0) begin
              timer_reg <= timer_reg - 1'b1;
            end else begin
              tx_reg    <= {1'b1, i_rd_data[7:0], 1'b0};
              hi_reg    <= i_rd_data[15:8];
              tx_hi_reg <= 1'b0;
              oe_reg    <= 1'b1;
              bit_reg   <= '0;
              timer_reg <= 18'(per_reg) - 18'd1;
              state_reg <= DEV_TX;
            end
          end
          DEV_TX: begin
            if (timer_reg != '0) begin
              timer_reg <= timer_reg - 1'b1;
            end else begin
              timer_reg <= 18'(per_reg) - 18'd1;
              if (bit_reg != `OWC_LAST_BIT) begin
                bit_reg <= bit_reg + 1'b1;
                tx_reg  <= {1'b1, tx_reg[9:1]};
                oe_reg  <= ~tx_reg[1];
              end else begin
                byte_done_reg <= 1'b1;
                bit_reg       <= '0;
                if (!tx_hi_reg) begin
                  tx_reg    <= {1'b1, hi_reg, 1'b0};
                  tx_hi_reg <= 1'b1;
                  oe_reg    <= 1'b1;
                end else begin
                  oe_reg    <= 1'b0;
                  state_reg <= DEV_HUNT;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // ===========================================================================
  // Write queue
  owc_fifo #(
    .WIDTH (20),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_valid (push_reg),
    .o_ready (fifo_ready),
    .i_data  ({addr_reg, rx_reg, lo_reg}),
    .o_valid (o_wr_valid),
    .i_ready (i_wr_ready),
    .o_data  ({o_wr_addr, o_wr_data})
  );
endmodule : owc_dev

`default_nettype wire

// >>> rtl/owc_consts.svh
// Purpose: Shared constants of the single-wire configuration port.
// Assumes: 50 MHz system clock on both ends.
// Notes:   Timing figures keep their own units; cycle counts derive from them.
`ifndef OWC_CONSTS_SVH
`define OWC_CONSTS_SVH

// =============================================================================
// Framing
`define OWC_SYNC_BYTE    8'h55
`define OWC_LAST_BIT     4'd9
`define OWC_RD_BIT       7
`define OWC_SYNC_RISES   3'd4
`define OWC_SYNC_SHIFT   3
`define OWC_TURN_DEF     4'd2

// =============================================================================
// Timing
`define OWC_CLK_HZ       50000000
`define OWC_BAUD_MIN     4800
`define OWC_BAUD_MAX     114000
`define OWC_TIMEOUT_MS   28
`define OWC_PER_MIN      ((`OWC_CLK_HZ + `OWC_BAUD_MAX - 1) / `OWC_BAUD_MAX)
`define OWC_PER_MAX      (`OWC_CLK_HZ / `OWC_BAUD_MIN)
`define OWC_MEAS_MAX     (8 * `OWC_PER_MAX)
`define OWC_TO_CYCLES    (`OWC_TIMEOUT_MS * (`OWC_CLK_HZ / 1000))
`define OWC_HOST_DIV     (`OWC_CLK_HZ / 9600)
`define OWC_HOST_WAIT    16

`endif

// >>> rtl/owc_pkg.sv
// Purpose: Types shared by both ends of the single-wire configuration port.
// Assumes: Nothing beyond the constants header.
// Notes:   Address field is the low nibble of the command byte.
package owc_pkg;

  // ===========================================================================
  // Data types
  typedef logic [3:0]  owc_addr_type;
  typedef logic [15:0] owc_word_type;
  typedef logic [13:0] owc_per_type;

  // ===========================================================================
  // State machines
  typedef enum logic [2:0] {
    DEV_HUNT, DEV_SYNC, DEV_IDLE, DEV_RX, DEV_TURN, DEV_TX
  } owc_dev_state_type;

  typedef enum logic [2:0] {
    HOST_IDLE, HOST_TX, HOST_WAIT, HOST_RX
  } owc_host_state_type;

endpackage : owc_pkg

// >>> rtl/owc_if.sv
// Purpose: Open-drain single wire joining controller and device.
// Assumes: External pull-up; either party may only pull the wire low.
// Notes:   The wire level is resolved here from both output enables.
`timescale 1ns/10ps
`default_nettype none

interface owc_if;
  logic dev_out;
  logic dev_oe;
  logic host_out;
  logic host_oe;
  logic line;

  // Pull-up wins unless somebody drives a low.
  assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

  modport dev  (input line, output dev_out, output dev_oe);
  modport host (input line, output host_out, output host_oe);
endinterface : owc_if

`default_nettype wire

// >>> rtl/owc_host.sv
// Purpose: Controller end of the single-wire configuration port.
// Assumes: Fixed bit period set by parameter, within the device's range.
// Notes:   Open drain only; the wire is released for the whole read answer.
`include "owc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module owc_host #(
  parameter int unsigned DIV  = `OWC_HOST_DIV,
  parameter int unsigned WAIT = `OWC_HOST_WAIT
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  owc_if.host                link,
  input  wire logic          i_start,
  input  wire logic          i_read,
  input  wire owc_pkg::owc_addr_type i_addr,
  input  wire owc_pkg::owc_word_type i_wdata,
  output logic               o_busy,
  output logic               o_done,
  output owc_pkg::owc_word_type o_rdata,
  output logic               o_err
);
  import owc_pkg::*;

  owc_host_state_type state_reg;
  logic [2:0]  sync_reg;
  logic        line_reg;
  logic        line_next;
  logic [17:0] timer_reg;
  logic [21:0] wait_reg;
  logic [3:0]  bit_reg;
  logic [9:0]  tx_reg;
  logic [1:0]  idx_reg;
  logic        read_reg;
  logic [7:0]  cmd_reg;
  logic [15:0] wdata_reg;
  logic [7:0]  rx_reg;
  logic        oe_reg;

  assign link.host_out = 1'b0;
  assign link.host_oe  = oe_reg;

  // Builds one ten-bit frame, sent from bit 0 upward.
  function automatic logic [9:0] frame(input logic [7:0] data);
    frame = {1'b1, data, 1'b0};
  endfunction : frame

  // ===========================================================================
  // Line synchroniser and glitch filter
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_reg <= 3'b111;
      line_reg <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], link.line};
      line_reg <= line_next;
    end
  end

  assign line_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : line_reg;

  // ===========================================================================
  // Transaction sequencer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= HOST_IDLE;
      timer_reg <= '0;
      wait_reg  <= '0;
      bit_reg   <= '0;
      tx_reg    <= '1;
      idx_reg   <= '0;
      read_reg  <= 1'b0;
      cmd_reg   <= '0;
      wdata_reg <= '0;
      rx_reg    <= '0;
      oe_reg    <= 1'b0;
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_rdata   <= '0;
      o_err     <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_err  <= 1'b0;
      unique case (state_reg)
        HOST_IDLE: begin
          if (i_start) begin
            read_reg  <= i_read;
            cmd_reg   <= {i_read, 3'b000, i_addr};
            wdata_reg <= i_wdata;
            tx_reg    <= frame(`OWC_SYNC_BYTE);
            oe_reg    <= 1'b1;
            idx_reg   <= '0;
            bit_reg   <= '0;
            timer_reg <= 18'(DIV - 1);
            o_busy    <= 1'b1;
            state_reg <= HOST_TX;
          end
        end
        HOST_TX: begin
          if (timer_reg != '0) begin
            timer_reg <= timer_reg - 1'b1;
          end else begin
            timer_reg <= 18'(DIV - 1);
            if (bit_reg != `OWC_LAST_BIT) begin
              bit_reg <= bit_reg + 1'b1;
              tx_reg  <= {1'b1, tx_reg[9:1]};
              oe_reg  <= ~tx_reg[1];
            end else begin
              bit_reg <= '0;
              idx_reg <= idx_reg + 1'b1;
              if (idx_reg == 2'd0) begin
                tx_reg <= frame(cmd_reg);
                oe_reg <= 1'b1;
              end else if (idx_reg == 2'd1 && read_reg) begin
                oe_reg    <= 1'b0;
                idx_reg   <= '0;
                wait_reg  <= '0;
                state_reg <= HOST_WAIT;
              end else if (idx_reg != 2'd3) begin
                tx_reg <= frame(idx_reg == 2'd1 ? wdata_reg[7:0] : wdata_reg[15:8]);
                oe_reg <= 1'b1;
              end else begin
                oe_reg    <= 1'b0;
                o_busy    <= 1'b0;
                o_done    <= 1'b1;
                state_reg <= HOST_IDLE;
              end
            end
          end
        end
        HOST_WAIT: begin
          wait_reg <= wait_reg + 1'b1;
          if (!line_reg) begin
            timer_reg <= 18'(DIV / 2);
            bit_reg   <= '0;
            state_reg <= HOST_RX;
          end else if (wait_reg == 22'(WAIT * DIV)) begin
            o_err     <= 1'b1;
            o_busy    <= 1'b0;
            state_reg <= HOST_IDLE;
          end
        end
        HOST_RX: begin
          if (timer_reg != '0) begin
            timer_reg <= timer_reg - 1'b1;
          end else if (idx_reg == 2'd2) begin
            // The answer's last stop bit runs out before a new sync may start.
            o_busy    <= 1'b0;
            o_done    <= 1'b1;
            state_reg <= HOST_IDLE;
          end else begin
            timer_reg <= 18'(DIV - 1);
            bit_reg   <= bit_reg + 1'b1;
            if (bit_reg != `OWC_LAST_BIT) begin
              if (bit_reg != 4'd0) begin
                rx_reg <= {line_reg, rx_reg[7:1]};
              end
            end else if (!line_reg) begin
              o_err     <= 1'b1;
              o_busy    <= 1'b0;
              state_reg <= HOST_IDLE;
            end else if (idx_reg == 2'd0) begin
              o_rdata[7:0] <= rx_reg;
              idx_reg      <= 2'd1;
              wait_reg     <= '0;
              state_reg    <= HOST_WAIT;
            end else begin
              o_rdata[15:8] <= rx_reg;
              idx_reg       <= 2'd2;
              timer_reg     <= 18'(DIV / 2);
            end
          end
        end
      endcase
    end
  end
endmodule : owc_host

`default_nettype wire

// >>> sim/owc_checker.sv
// Purpose: Concurrent checks on the wire between the two ends.
// Assumes: Host bit period of PER clock cycles.
// Notes:   Counters give the length of the current run of the device output enable and the cycles since the host last pulled low.
`timescale 1ns/10ps
`default_nettype none

// =====
// Checker
module owc_checker #(
  parameter int PER = 440
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic line
);
  int   run_reg;
  int   quiet_reg;
  logic prev_reg;

  // Bit timing is checked with a few cycles of slack for the input synchroniser.
  always_ff @(posedge i_clock) begin
    prev_reg <= i_rst ? 1'b0 : dev_oe;
    run_reg  <= (i_rst || dev_oe != prev_reg) ? 1 : run_reg + 1;
  end

  always_ff @(posedge i_clock) begin
    quiet_reg <= (i_rst || host_oe) ? 0 : quiet_reg + 1;
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence dev_grab;
    $rose(dev_oe);
  endsequence

  sequence dev_free;
    $fell(dev_oe);
  endsequence

  chk_dev_low_only: assert property (dev_oe |-> !dev_out) else $error("device drove high");
  chk_host_low_only: assert property (host_oe |-> !host_out) else $error("host drove high");
  chk_host_released: assert property (dev_oe |-> !host_oe) else $error("host not released");
  chk_idle_high: assert property ($fell(i_rst) |-> line && !dev_oe && !host_oe)
    else $error("wire not idle after reset");
  chk_start_hold: assert property (dev_grab |-> dev_oe [*8]) else $error("short pull");
  chk_host_start: assert property ($rose(host_oe) |-> host_oe [*8]) else $error("short pull");
  chk_low_run_len: assert property (dev_free |-> run_reg inside {[PER-3:9*PER+3]})
    else $error("device low run has wrong length");
  chk_stop_gap: assert property (dev_grab |-> run_reg >= PER - 3) else $error("short high");
  // Stop bit plus a turnaround of at least two periods; the bench never sets fewer.
  chk_turn_wait: assert property (dev_grab |-> quiet_reg >= 3 * PER)
    else $error("device answered too early");
endmodule : owc_checker

`default_nettype wire

// >>> sim/one_wire_uart_config_port_test.sv
// Purpose: Self-checking bench for both ends of the single-wire port.
// Assumes: Shortened timeout and FIFO depth keep the run brief.
// Notes:   A second device faces a bench driver that breaks the framing.
`timescale 1ns/10ps
`default_nettype none

// =====
// Bench
module one_wire_uart_config_port_test;
  import owc_pkg::*;
  localparam int P  = 440;
  localparam int PB = 520;
  localparam int TO = 14000;
  logic         i_clock = 1'b0, i_rst = 1'b1, start = 1'b0, rd = 1'b0, wr_ready = 1'b0;
  logic [3:0]   turn = 4'h0;
  owc_addr_type addr = 4'h0, wr_addr, rd_addr, b_addr;
  owc_word_type wdata = 16'h0000, rd_data = 16'h0000, rdata, wr_data, b_data;
  logic         done, err, wr_valid, rd_req, ovf, b_valid, b_req, b_ferr, busy, a_ferr;
  int           n_errors = 0, n_checks = 0, cyc = 0, n_ovf = 0, n_req = 0, n_ferr = 0, n_breq = 0;
  int           n_lerr = 0;
  logic [19:0]  qa[$], qb[$];

  owc_if link_a();
  owc_if link_b();

  owc_host #(.DIV(P)) owc_host_i (.i_clock(i_clock), .i_rst(i_rst), .link(link_a.host),
    .i_start(start), .i_read(rd), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .o_err(err));
  owc_dev #(.TIMEOUT_CYCLES(TO), .FIFO_DEPTH(2)) owc_dev_i (.i_clock(i_clock), .i_rst(i_rst),
    .link(link_a.dev), .i_turn_bits(turn), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .o_overflow(ovf), .o_frame_err(a_ferr));
  owc_dev #(.TIMEOUT_CYCLES(TO), .FIFO_DEPTH(2)) owc_dev_fault_i (.i_clock(i_clock),
    .i_rst(i_rst), .link(link_b.dev), .i_turn_bits(turn), .o_wr_valid(b_valid),
    .i_wr_ready(1'b1), .o_wr_addr(b_addr), .o_wr_data(b_data), .o_rd_req(b_req),
    .o_rd_addr(), .i_rd_data(rd_data), .o_overflow(), .o_frame_err(b_ferr));
  owc_checker #(.PER(P)) owc_checker_i (.i_clock(i_clock), .i_rst(i_rst),
    .dev_out(link_a.dev_out), .dev_oe(link_a.dev_oe), .host_out(link_a.host_out),
    .host_oe(link_a.host_oe), .line(link_a.line));

  always #10 i_clock = ~i_clock;

  // Five transfers of 40 to 43 bit periods each, plus margin.
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    if (ovf === 1'b1) n_ovf++;
    if (rd_req === 1'b1) n_req++;
    if (b_ferr === 1'b1) n_ferr++;
    if (b_req === 1'b1) n_breq++;
    if (err === 1'b1 || a_ferr === 1'b1) n_lerr++;
    if (wr_valid === 1'b1 && wr_ready) check({wr_addr, wr_data}, qa.pop_front());
    if (b_valid === 1'b1) check({b_addr, b_data}, qb.pop_front());
    if (cyc == 100000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Samples four frames mid-bit on the shared wire.
  task automatic watch(input logic [31:0] exp);
    logic [9:0] f;
    int k;
    for (int n = 0; n < 4; n++) begin
      k = 0;
      while (link_a.line !== 1'b0 && k < 40000) begin
        @(posedge i_clock);
        k++;
      end
      repeat (P / 2) @(posedge i_clock);
      for (int b = 0; b < 10; b++) begin
        f[b] = link_a.line;
        if (b < 9) repeat (P) @(posedge i_clock);
      end
      check({f[9], f[0]}, 2'b10);
      check(f[8:1] & ((n == 1) ? 8'h8f : 8'hff), exp[8*n +: 8]);
    end
  endtask : watch

  task automatic xfer(input logic r, input logic [19:0] w);
    int k;
    int t0;
    int t1;
    int gap;
    rd = r;
    addr = w[19:16];
    wdata = w[15:0];
    rd_data = w[15:0];
    start = 1'b1;
    fork
      watch({w[15:0], r, 3'b000, w[19:16], 8'h55});
      begin
        @(posedge i_clock);
        #1;
        start = 1'b0;
        while (done !== 1'b1 && k < 30000) begin
          if (t0 == 0 && link_a.host_oe) t0 = cyc;
          if (t1 == 0 && link_a.dev_oe) t1 = cyc;
          @(posedge i_clock);
          #1;
          k++;
        end
      end
    join
    gap = t1 - t0 - 20 * P - ((turn == 4'h0) ? 2 : int'(turn)) * P;
    check(n_lerr, 0);
    check(k < 30000, 1'b1);
    check(busy, 1'b0);
    if (r) begin
      check(rdata, w[15:0]);
      check(rd_addr, w[19:16]);
      check(gap inside {[-8:24]}, 1'b1);
    end
  endtask : xfer

  task automatic drv(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      link_b.host_oe = ~f[i];
      repeat (PB) @(posedge i_clock);
      #1;
    end
  endtask : drv

  task automatic fault();
    drv(8'h55, 1'b1);
    repeat (TO + 2000) @(posedge i_clock);
    #1;
    qb.push_back(20'h65a3c);
    drv(8'h55, 1'b1);
    drv(8'h06, 1'b1);
    drv(8'h3c, 1'b1);
    drv(8'h5a, 1'b1);
    drv(8'h55, 1'b1);
    drv(8'h86, 1'b0);
    link_b.host_oe = 1'b0;
    repeat (PB) @(posedge i_clock);
    check(qb.size(), 0);
    check(n_ferr, 1);
    check(n_breq, 0);
    $display("fault test done");
  endtask : fault

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    logic [31:0] w;
    link_b.host_out = 1'b0;
    link_b.host_oe = 1'b0;
    w = $urandom(32'h885d0556);
    repeat (12) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    fork
      begin
        for (int i = 0; i < 3; i++) begin
          w = $urandom;
          if (i < 2) qa.push_back(w[19:0]);
          xfer(1'b0, w[19:0]);
        end
        check(n_ovf, 1);
        $display("write test done");
        wr_ready = 1'b1;
        for (int i = 0; i < 2; i++) begin
          turn = 4'(3 * i);
          w = $urandom;
          xfer(1'b1, w[19:0]);
        end
        check(qa.size(), 0);
        check(n_req, 2);
        $display("read test done");
      end
      fault();
    join
    tally_and_finish();
  end
endmodule : one_wire_uart_config_port_test

`default_nettype wire
